//--- rcms_defines.svh
// constants for the reset, clock and mode-select front end
// assumes sys_clk is the oscillator input at 250 MHz; one output clock = two sys_clk
`ifndef RCMS_DEFINES_SVH
`define RCMS_DEFINES_SVH
`define RCMS_SYNC_STAGES     2
`define RCMS_RST_HOLD_OCLK   2
`define RCMS_FETCH_DLY_HALF  13
`define RCMS_STRAP_DLY_OCLK  4
`define RCMS_WAIT_POLL_OCLK  5
`define RCMS_CNT_W           5
`endif

//--- rcms_pkg.sv
// types for the reset, clock and mode-select front end
// assumes rcms_defines.svh is compiled alongside
package rcms_pkg;
  typedef enum logic {RCMS_LEGACY, RCMS_EXTENDED} rcms_mode_t;
  typedef struct packed {
    logic waitReq;
    logic fpReq;
  } rcms_core_req_t;
  typedef struct packed {
    logic       coreRun;
    logic       fetchStart;
    rcms_mode_t mode;
    logic       waitSuspended;
    logic       fpIssue;
  } rcms_core_stat_t;
endpackage

//--- rcms_clk_div.sv
// divide-by-two of the oscillator input, plus the phase enable pulse
// assumes a free-running sys_clk; reset only sets the phase
`include "rcms_defines.svh"
module rcms_clk_div
  import rcms_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset,
  output logic      divClk,
  output logic      oclkRise
);
  logic divClk_q;
  logic divClk_d;

  // single toggle flop keeps both phases equal; reset holds it high
  always_comb
  begin
    divClk_d = ~divClk_q;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    // starts high so the re-timed output pin already toggles on the first edge after reset
    if (reset)
      divClk_q <= 1'b1;
    else
      divClk_q <= divClk_d;
  end

  assign divClk   = divClk_q;
  assign oclkRise = ~divClk_q; // next edge raises the output clock
endmodule // rcms_clk_div

//--- rcms_sync.sv
// two-flop synchroniser for the asynchronous power-on clear input
// assumes the input may change at any time
`include "rcms_defines.svh"
module rcms_sync
  import rcms_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic [`RCMS_SYNC_STAGES-1:0] stage_q;
  logic [`RCMS_SYNC_STAGES-1:0] stage_d;

  // first stage is read only by the second
  always_comb
  begin
    stage_d = {stage_q[`RCMS_SYNC_STAGES-2:0], asyncIn};
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      stage_q <= '0;
    else
      stage_q <= stage_d;
  end

  assign syncOut = stage_q[`RCMS_SYNC_STAGES-1];
endmodule // rcms_sync

//--- rcms_front_end.sv
// reset, clock divider and mode strap front end of a processor core
// assumes sys_clk is the oscillator input and reset is the power-up reset
// Notes on behaviour
// - output clock is the oscillator input divided by two
// - output clock has equal phases; pin timing follows it
// - output clock keeps running while clear is held low; power-up reset holds it
// - active clear input stops the core and holds it idle
// - clear input is asynchronous and synchronised inside
// - fetching starts about six and a half clocks after clear release
// - extended mode only if strap high at release, low four clocks later
// - strap is sampled during and after reset for the mode
// - strap pin is never driven; it is an input only
// - legacy mode: strap pin is the wait-gate input
// - wait-gate high at wait start suspends execution
// - suspended core polls the gate every five clocks, resumes when low
// - interrupts are still serviced while suspended if enabled
// - extended mode: pin is coprocessor busy; commands issue when not busy
// - system reset output is synchronous and tracks clear length
// - system reset output drops two output clocks after clear release
`include "rcms_defines.svh"
module rcms_front_end
  import rcms_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            reset,
  input  wire logic            power_on_clear_input_n,
  input  wire logic            strapPin,
  input  wire logic            intEnable,
  input  wire logic            intPending,
  input  wire rcms_core_req_t  coreReq,
  output logic                 divided_clock_output,
  output logic                 oscillator_feedback_output,
  output logic                 strapOe,
  output logic                 sysReset,
  output logic                 intService,
  output rcms_core_stat_t      coreStat
);
  typedef enum logic [1:0] {RCMS_S_RESET, RCMS_S_HOLD, RCMS_S_RUN} rcms_state_t;

  logic                  divClk;
  logic                  oclkRise;
  logic                  clearSync;
  rcms_state_t           state_q;
  rcms_state_t           state_d;
  logic [`RCMS_CNT_W-1:0] cnt_q;
  logic [`RCMS_CNT_W-1:0] cnt_d;
  logic                  sysReset_q;
  logic                  sysReset_d;
  logic                  strapAtRise_q;
  logic                  strapAtRise_d;
  logic [2:0]            strapCnt_q;
  logic [2:0]            strapCnt_d;
  logic                  strapPend_q;
  logic                  strapPend_d;
  rcms_mode_t            mode_q;
  rcms_mode_t            mode_d;
  logic                  fetch_q;
  logic                  fetch_d;
  logic                  susp_q;
  logic                  susp_d;
  logic [2:0]            poll_q;
  logic [2:0]            poll_d;
  logic                  fpIssue_q;
  logic                  fpIssue_d;
  logic                  intSvc_q;
  logic                  intSvc_d;
  logic                  divided_clock_output_q;
  logic                  divided_clock_output_d;
  logic                  oscFb_q;
  logic                  oscFb_d;
  logic                  coreRun_q;
  logic                  coreRun_d;

  // last count of a small enable-paced counter; shared by strap and poll timing
  function automatic logic isLastCount(
    input logic [2:0] count,
    input int         limit
  );
    return count == 3'(limit - 1);
  endfunction

  rcms_clk_div u_div (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .divClk   (divClk),
    .oclkRise (oclkRise)
  );

  rcms_sync u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .asyncIn (power_on_clear_input_n),
    .syncOut (clearSync)
  );

  // output pins re-timed so each leaves a flop
  always_comb
  begin
    divided_clock_output_d = divClk;
    oscFb_d  = ~divClk;
  end

  // reset sequencing: clear input, system reset output and fetch start
  always_comb
  begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    sysReset_d = sysReset_q;
    fetch_d    = 1'b0;
    case (state_q)
      RCMS_S_RESET:
      begin
        sysReset_d = 1'b1;
        cnt_d      = '0;
        if (clearSync)
          state_d = RCMS_S_HOLD;
      end
      RCMS_S_HOLD:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == 5'(2 * `RCMS_RST_HOLD_OCLK - 1))
          sysReset_d = 1'b0;
        if (cnt_q == 5'(`RCMS_FETCH_DLY_HALF - 1))
        begin
          fetch_d = 1'b1;
          state_d = RCMS_S_RUN;
        end
      end
      default:
      begin
      end
    endcase
    if (!clearSync)
    begin
      state_d    = RCMS_S_RESET;
      sysReset_d = 1'b1;
    end
  end

  // mode strap capture; release is the synchronised rising edge of clear
  always_comb
  begin
    strapAtRise_d = strapAtRise_q;
    strapCnt_d    = strapCnt_q;
    strapPend_d   = strapPend_q;
    mode_d        = mode_q;
    if (state_q == RCMS_S_RESET && clearSync)
    begin
      strapAtRise_d = strapPin;
      strapCnt_d    = '0;
      strapPend_d   = 1'b1;
    end
    else if (strapPend_q && oclkRise)
    begin
      strapCnt_d = strapCnt_q + 1'b1;
      // high then low four clocks later
      if (isLastCount(strapCnt_q, `RCMS_STRAP_DLY_OCLK))
      begin
        strapPend_d = 1'b0;
        mode_d      = (strapAtRise_q && !strapPin) ? RCMS_EXTENDED : RCMS_LEGACY;
      end
    end
    if (!clearSync)
    begin
      strapPend_d = 1'b0;
      mode_d      = RCMS_LEGACY;
    end
  end

  // wait-gate suspension, coprocessor busy gating and interrupt service
  always_comb
  begin
    susp_d    = susp_q;
    poll_d    = poll_q;
    fpIssue_d = 1'b0;
    intSvc_d  = 1'b0;
    if (state_q == RCMS_S_RUN && !strapPend_q)
    begin
      if (mode_q == RCMS_LEGACY && !susp_q && coreReq.waitReq && strapPin)
      begin
        susp_d = 1'b1;
        poll_d = '0;
      end
      else if (susp_q && oclkRise)
      begin
        poll_d = isLastCount(poll_q, `RCMS_WAIT_POLL_OCLK) ? 3'h0 : poll_q + 1'b1;
        if (isLastCount(poll_q, `RCMS_WAIT_POLL_OCLK) && !strapPin)
          susp_d = 1'b0;
      end
      intSvc_d = susp_q && intEnable && intPending;
      fpIssue_d = mode_q == RCMS_EXTENDED && coreReq.fpReq && !strapPin;
    end
    if (!clearSync)
    begin
      susp_d = 1'b0;
      poll_d = '0;
    end
    // run flag leaves a flop, so it is built from the next state values
    coreRun_d = (state_d == RCMS_S_RUN) && !susp_d;
  end

  // output pin registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      divided_clock_output_q <= 1'b0;
      oscFb_q  <= 1'b1;
    end
    else
    begin
      divided_clock_output_q <= divided_clock_output_d;
      oscFb_q  <= oscFb_d;
    end
  end

  // reset sequencing registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_q    <= RCMS_S_RESET;
      cnt_q      <= '0;
      sysReset_q <= 1'b1;
      fetch_q    <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      sysReset_q <= sysReset_d;
      fetch_q    <= fetch_d;
    end
  end

  // mode strap registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      strapAtRise_q <= 1'b0;
      strapCnt_q    <= '0;
      strapPend_q   <= 1'b0;
      mode_q        <= RCMS_LEGACY;
    end
    else
    begin
      strapAtRise_q <= strapAtRise_d;
      strapCnt_q    <= strapCnt_d;
      strapPend_q   <= strapPend_d;
      mode_q        <= mode_d;
    end
  end

  // wait, coprocessor and interrupt registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      susp_q    <= 1'b0;
      poll_q    <= '0;
      fpIssue_q <= 1'b0;
      intSvc_q  <= 1'b0;
      coreRun_q <= 1'b0;
    end
    else
    begin
      susp_q    <= susp_d;
      poll_q    <= poll_d;
      fpIssue_q <= fpIssue_d;
      intSvc_q  <= intSvc_d;
      coreRun_q <= coreRun_d;
    end
  end

  assign strapOe                    = 1'b0;
  assign divided_clock_output       = divided_clock_output_q;
  assign oscillator_feedback_output = oscFb_q;
  assign sysReset                   = sysReset_q;
  assign intService                 = intSvc_q;
  assign coreStat.coreRun           = coreRun_q;
  assign coreStat.fetchStart        = fetch_q;
  assign coreStat.mode              = mode_q;
  assign coreStat.waitSuspended     = susp_q;
  assign coreStat.fpIssue           = fpIssue_q;
endmodule // rcms_front_end

//--- rcms_front_end_assertions.sv
// checker for the front end: clock, clear, mode and wait timing
// assumes it is bound to rcms_front_end; one sys_clk domain
module rcms_front_end_assertions
  import rcms_pkg::*;
(
  input wire logic            sys_clk,
  input wire logic            reset,
  input wire logic            power_on_clear_input_n,
  input wire logic            strapPin,
  input wire logic            intEnable,
  input wire logic            intPending,
  input wire rcms_core_req_t  coreReq,
  input wire logic            divided_clock_output,
  input wire logic            oscillator_feedback_output,
  input wire logic            strapOe,
  input wire logic            sysReset,
  input wire logic            intService,
  input wire rcms_core_stat_t coreStat
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // clock toggles on every edge, even with clear held low
  property p_div_toggle; 1 |=> divided_clock_output != $past(divided_clock_output); endproperty
  a_div_toggle: assert property (p_div_toggle) else $error("output clock stalled");
  property p_duty; oscillator_feedback_output == !divided_clock_output; endproperty
  a_duty: assert property (p_duty) else $error("clock phases unequal");
  // four low samples cover the two sync flops plus the state flop
  property p_clear_idle; !power_on_clear_input_n [*4] |-> sysReset && !coreStat.coreRun; endproperty
  a_clear_idle: assert property (p_clear_idle) else $error("core not idle under clear");
  property p_rst_drop; $rose(power_on_clear_input_n) && sysReset |-> ##[5:9] $fell(sysReset); endproperty
  a_rst_drop: assert property (p_rst_drop) else $error("system reset drop late or early");
  property p_fetch; $fell(sysReset) |-> ##9 coreStat.fetchStart; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch start misplaced");
  property p_no_drive; strapOe == 1'b0; endproperty
  a_no_drive: assert property (p_no_drive) else $error("strap pin driven");
  property p_wait_susp;
    coreReq.waitReq && strapPin && coreStat.coreRun && coreStat.mode == RCMS_LEGACY |=> coreStat.waitSuspended;
  endproperty
  a_wait_susp: assert property (p_wait_susp) else $error("wait did not suspend");
  // gate polled every five output clocks, so resume lands within twelve edges
  property p_wait_poll; coreStat.waitSuspended && !strapPin |-> ##[1:12] !coreStat.waitSuspended; endproperty
  a_wait_poll: assert property (p_wait_poll) else $error("wait did not resume");
  property p_int; coreStat.waitSuspended && intEnable && intPending |=> intService; endproperty
  a_int: assert property (p_int) else $error("interrupt not serviced");
  property p_busy; coreStat.mode == RCMS_EXTENDED && strapPin |=> !coreStat.fpIssue; endproperty
  a_busy: assert property (p_busy) else $error("issue while busy");
endmodule // rcms_front_end_assertions

bind rcms_front_end rcms_front_end_assertions u_chk (
  .sys_clk(sys_clk), .reset(reset), .power_on_clear_input_n(power_on_clear_input_n),
  .strapPin(strapPin), .intEnable(intEnable), .intPending(intPending), .coreReq(coreReq),
  .divided_clock_output(divided_clock_output), .oscillator_feedback_output(oscillator_feedback_output),
  .strapOe(strapOe), .sysReset(sysReset), .intService(intService), .coreStat(coreStat));

//--- rcms_far_side.sv
// far side model: clear source, board strap wiring, gate or busy level
// assumes the bench changes its controls at the falling edge
module rcms_far_side
  import rcms_pkg::*;
(
  input  wire logic clearHold,
  input  wire logic tieReset,
  input  wire logic sysReset,
  input  wire logic gateLevel,
  output logic      clearN,
  output logic      strapLevel
);
  timeunit 1ns;
  timeprecision 100ps;
  // clear held low as long as the bench asks
  assign clearN = !clearHold;
  // board ties system reset onto the strap; or-ed with busy
  assign strapLevel = (tieReset & sysReset) | gateLevel;
endmodule // rcms_far_side

//--- tb_rcms_front_end.sv
// self-checking bench for the reset, clock and mode front end
// assumes the far side model drives clear and strap
module tb_rcms_front_end
  import rcms_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic            sys_clk, reset, clearHold, tieReset, gateLevel, intEnable, intPending;
  logic            clearN, strap, divOut, fbOut, strapOe, sysReset, intService;
  rcms_core_req_t  coreReq;
  rcms_core_stat_t coreStat;
  int              errCount, cmpCount;

  rcms_front_end dut (.sys_clk(sys_clk), .reset(reset), .power_on_clear_input_n(clearN), .strapPin(strap),
    .intEnable(intEnable), .intPending(intPending), .coreReq(coreReq), .divided_clock_output(divOut),
    .oscillator_feedback_output(fbOut), .strapOe(strapOe), .sysReset(sysReset), .intService(intService),
    .coreStat(coreStat));
  rcms_far_side far (.clearHold(clearHold), .tieReset(tieReset), .sysReset(sysReset),
    .gateLevel(gateLevel), .clearN(clearN), .strapLevel(strap));

  // 250 MHz oscillator
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic check(input logic seen, input logic exp);
    cmpCount++;
    if (seen !== exp)
    begin
      errCount++;
      $display("FAIL %0t seen %b want %b", $time, seen, exp);
    end
  endtask

  task automatic finalReport();
    $display("compares %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // a loop that ran out of bound ends the run
  task automatic bound(input int n, input int lim);
    if (n >= lim)
    begin
      errCount++;
      $display("FAIL %0t wait timed out", $time);
      finalReport();
    end
  endtask

  // clear pulse with a given strap wiring, then check fetch and mode
  task automatic test_boot(input logic tie, input logic gate, input logic expMode);
    int n;
    @(negedge sys_clk);
    tieReset = tie;
    gateLevel = gate;
    clearHold = 1'b1;
    repeat (12) @(negedge sys_clk);
    check(sysReset, 1'b1);
    check(coreStat.coreRun, 1'b0);
    clearHold = 1'b0;
    n = 0;
    while (coreStat.fetchStart !== 1'b1 && n < 40)
    begin
      @(negedge sys_clk);
      n++;
    end
    bound(n, 40);
    check(n >= 14 && n <= 18, 1'b1);
    check(sysReset, 1'b0);
    check(coreStat.mode, expMode);
    gateLevel = 1'b0;
    $display("boot test done");
  endtask

  // legacy wait on the gate, interrupt service while suspended
  task automatic test_wait();
    int n;
    @(negedge sys_clk);
    gateLevel = 1'b1;
    coreReq.waitReq = 1'b1;
    @(negedge sys_clk);
    coreReq.waitReq = 1'b0;
    @(negedge sys_clk);
    check(coreStat.waitSuspended, 1'b1);
    check(coreStat.coreRun, 1'b0);
    intEnable = 1'b1;
    intPending = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(intService, 1'b1);
    intEnable = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(intService, 1'b0);
    intPending = 1'b0;
    repeat (20) @(negedge sys_clk);
    check(coreStat.waitSuspended, 1'b1);
    gateLevel = 1'b0;
    n = 0;
    while (coreStat.waitSuspended === 1'b1 && n < 14)
    begin
      @(negedge sys_clk);
      n++;
    end
    bound(n, 14);
    check(n <= 12, 1'b1);
    $display("wait test done");
  endtask

  // extended mode: no issue while busy, issue soon after busy drops
  task automatic test_fp();
    int n;
    @(negedge sys_clk);
    gateLevel = 1'b1;
    coreReq.fpReq = 1'b1;
    repeat (6)
    begin
      @(negedge sys_clk);
      check(coreStat.fpIssue, 1'b0);
    end
    gateLevel = 1'b0;
    n = 0;
    while (coreStat.fpIssue !== 1'b1 && n < 6)
    begin
      @(negedge sys_clk);
      n++;
    end
    bound(n, 6);
    check(coreStat.fpIssue, 1'b1);
    coreReq.fpReq = 1'b0;
    $display("coprocessor test done");
  endtask

  // power-up reset, then the scenarios; later boots abort a running core
  initial
  begin
    reset = 1'b1;
    clearHold = 1'b1;
    tieReset = 1'b0;
    gateLevel = 1'b0;
    intEnable = 1'b0;
    intPending = 1'b0;
    coreReq = '0;
    errCount = 0;
    cmpCount = 0;
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    test_boot(1'b0, 1'b1, RCMS_LEGACY);
    test_boot(1'b1, 1'b0, RCMS_EXTENDED);
    test_fp();
    test_boot(1'b0, 1'b0, RCMS_LEGACY);
    test_wait();
    finalReport();
  end
endmodule // tb_rcms_front_end
